// >>> rtl/ires_defines.vh
// Constants for the interrupt recording and error flag unit.
`ifndef IRES_DEFINES_VH
`define IRES_DEFINES_VH
`define IRES_NUM_CAUSES      8
`define IRES_ERR_WIDTH       16
`define IRES_ERR_RESET       16'h0000
`define IRES_ERR_OVF_BIT     3
`define IRES_ERR_STK_BIT     2
`define IRES_ERR_LSE_BIT     1
`define IRES_ERR_RSV0_BIT    0
`define IRES_ERR_LOW_MASK    16'h000E
`define IRES_MASK_SET        1'h1
`define IRES_MASK_CLEAR      1'h0
`endif

// >>> rtl/ires_pending.v
// Per-cause pending request flags with acknowledge and flush.
`default_nettype none
`include "ires_defines.vh"
module ires_pending #(
  parameter N = `IRES_NUM_CAUSES
) (
  // Clock, reset and enable.
  input  wire         core_clk,
  input  wire         rst,
  input  wire         clk_en,
  // Requests, acknowledge and flush.
  input  wire [N-1:0] irq_req,
  input  wire [N-1:0] ack_onehot,
  input  wire         flush,
  // Recorded state.
  output reg  [N-1:0] pending
);
  // Each cause holds one recorded request; a new request wins over its own acknowledge.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pending <= {N{1'b0}};
    else if (clk_en)
    begin
      if (flush)
        pending <= {N{1'b0}};
      else
        pending <= (pending & ~ack_onehot) | irq_req;
    end
  end
endmodule // ires_pending
`default_nettype wire

// >>> rtl/ires_errflags.v
// Sticky error status register with software write access.
`default_nettype none
`include "ires_defines.vh"
module ires_errflags (
  // Clock, reset and enable.
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clk_en,
  // Error events.
  input  wire        ovf_evt,
  input  wire        stk_evt,
  input  wire        lse_evt,
  // Transfer instruction write.
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  // Register state.
  output reg  [15:0] flags
);
  wire [15:0] evt;
  assign evt = {12'h000, ovf_evt, stk_evt, lse_evt, 1'b0};

  // Write replaces the low flags, events are ORed on top so they win.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flags <= `IRES_ERR_RESET;
    else if (clk_en)
    begin
      if (wr_en)
        flags <= ((wr_data & `IRES_ERR_LOW_MASK) | evt);
      else
        flags <= flags | evt;
    end
  end
endmodule // ires_errflags
`default_nettype wire

// >>> rtl/ires_top.v
// Interrupt recording, masking and sticky error status unit of the DSP core.
// Functional notes
// - Acknowledging an interrupt sets the global mask flag to 1, blocking further acknowledges.
// - The return-from-handler instruction clears the global mask flag to 0.
// - A request arriving while acknowledge is blocked stays pending and is served once unmasked.
// - Every request is recorded whatever the global mask and per-cause enables say.
// - A cause records at most one request; repeats while pending merge.
// - A pending flag clears only on its own acknowledge or on flush.
// - The flush instruction clears every pending flag.
// - Service order among simultaneous requests is unspecified; here the lowest index goes first.
// - The error register is 16 bits and writes to bits 15 to 4 are ignored.
// - Error flags set on their event and stay set until reset or a software write.
// - The error register is reached only by the register transfer instruction.
// - Reset clears the error register to zero.
// - Bit 3 flags a 40-bit arithmetic overflow.
// - Bit 2 flags call stack overflow or underflow.
// - Bit 1 flags loop stack overflow or underflow.
// - Bit 0 carries no bus access error and always reads zero.
`default_nettype none
`include "ires_defines.vh"
module ires_top #(
  parameter N = `IRES_NUM_CAUSES
) (
  // Clock, reset and enable.
  input  wire         core_clk,
  input  wire         rst,
  input  wire         clk_en,
  // Interrupt sources and per-cause enables.
  input  wire [N-1:0] irq_req,
  input  wire [N-1:0] irq_enable,
  // Sequencer: acknowledge slot and instruction strobes.
  input  wire         ack_allowed,
  input  wire         return_from_handler_instr,
  input  wire         flush_pending_irq_instr,
  // Error detectors.
  input  wire         ovf_evt,
  input  wire         stk_evt,
  input  wire         lse_evt,
  // Register transfer access to the error register.
  input  wire         error_flags_wr,
  input  wire [15:0]  error_flags_wdata,
  // Outputs to the sequencer.
  output reg          irq_ack,
  output reg  [N-1:0] irq_ack_cause,
  output reg          global_irq_mask_flag,
  output reg  [N-1:0] irq_pending,
  output reg  [15:0]  error_flags_rdata
);
  wire [N-1:0] pending;
  wire [15:0]  flags;
  reg  [N-1:0] next_ack_onehot;
  wire         ack_fire;

  // Lowest set bit of a vector as a one-hot word.
  function [N-1:0] lowest_onehot;
    input [N-1:0] v;
    begin
      lowest_onehot = v & (~v + {{(N-1){1'b0}}, 1'b1});
    end
  endfunction

  // Pick one eligible recorded cause while not masked.
  always @*
  begin
    next_ack_onehot = {N{1'b0}};
    if (!global_irq_mask_flag && ack_allowed && !flush_pending_irq_instr)
      next_ack_onehot = lowest_onehot(pending & irq_enable);
  end
  assign ack_fire = |next_ack_onehot;

  ires_pending #(
    .N (N)
  ) u_pending (
    .core_clk   (core_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .irq_req    (irq_req),
    .ack_onehot (next_ack_onehot),
    .flush      (flush_pending_irq_instr),
    .pending    (pending)
  );

  ires_errflags u_err (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .ovf_evt  (ovf_evt),
    .stk_evt  (stk_evt),
    .lse_evt  (lse_evt),
    .wr_en    (error_flags_wr),
    .wr_data  (error_flags_wdata),
    .flags    (flags)
  );

  // Global mask, acknowledge pulse and registered views.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_mask_flag <= `IRES_MASK_CLEAR;
      irq_ack              <= 1'b0;
      irq_ack_cause        <= {N{1'b0}};
      irq_pending          <= {N{1'b0}};
      error_flags_rdata    <= `IRES_ERR_RESET;
    end
    else if (clk_en)
    begin
      if (ack_fire)
        global_irq_mask_flag <= `IRES_MASK_SET;
      else if (return_from_handler_instr)
        global_irq_mask_flag <= `IRES_MASK_CLEAR;
      irq_ack           <= ack_fire;
      irq_ack_cause     <= next_ack_onehot;
      irq_pending       <= pending;
      error_flags_rdata <= flags;
    end
  end
endmodule // ires_top
`default_nettype wire

// >>> sim/ires_checker_assertions.sv
// Concurrent checks on the ports of the interrupt and error flag unit.
`default_nettype none
module ires_checker #(parameter N = 8) (
  input wire logic         core_clk, rst, clk_en, ack_allowed, return_from_handler_instr,
  input wire logic         flush_pending_irq_instr, ovf_evt, stk_evt, lse_evt, error_flags_wr,
  input wire logic         irq_ack, global_irq_mask_flag,
  input wire logic [N-1:0] irq_req, irq_ack_cause, irq_pending,
  input wire logic [15:0]  error_flags_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A condition followed by one enabled edge.
  sequence s_run(a);
    a ##1 clk_en;
  endsequence
  a_ack_mask: assert property (irq_ack |-> global_irq_mask_flag) else $error("ack without mask");
  a_ack_single: assert property (irq_ack && clk_en |=> !irq_ack) else $error("ack twice");
  a_ret_clears: assert property (global_irq_mask_flag && return_from_handler_instr && clk_en
    |=> !global_irq_mask_flag) else $error("mask kept");
  a_ack_slot: assert property ($rose(irq_ack) |-> $past(ack_allowed) && $onehot(irq_ack_cause))
    else $error("bad ack");
  a_flush_all: assert property (s_run(clk_en && flush_pending_irq_instr) |=> irq_pending == 0)
    else $error("pending kept");
  a_req_kept: assert property (s_run(clk_en && !flush_pending_irq_instr)
    |=> (irq_pending & $past(irq_req, 2)) == $past(irq_req, 2)) else $error("lost");
  a_err_sticky: assert property (s_run(!error_flags_wr) |=> ($past(error_flags_rdata) & ~error_flags_rdata) == 0)
    else $error("flag lost");
  a_ovf_set: assert property (s_run(clk_en && ovf_evt) |=> error_flags_rdata[3]) else $error("ovf");
  a_stk_set: assert property (s_run(clk_en && stk_evt) |=> error_flags_rdata[2]) else $error("stk");
  a_lse_set: assert property (s_run(clk_en && lse_evt) |=> error_flags_rdata[1]) else $error("lse");
  a_unused_zero: assert property (error_flags_rdata[15:4] == 0 && !error_flags_rdata[0]) else $error("hi");
endmodule // ires_checker
`default_nettype wire

// >>> sim/ires_seq_model.sv
// Sequencer model: grants acknowledge slots and returns from each handler after a delay.
`default_nettype none
module ires_seq_model (
  input wire logic       core_clk, rst, irq_ack,
  input wire logic [3:0] dly,
  output logic           ack_allowed, return_from_handler_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Handler length counts down from each acknowledge.
  always @(posedge core_clk or posedge rst)
    if (rst) cnt <= 4'h0;
    else if (irq_ack) cnt <= dly;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  assign return_from_handler_instr = cnt == 4'h1;
  assign ack_allowed = cnt == 4'h0;
endmodule // ires_seq_model
`default_nettype wire

// >>> sim/ires_top_tb_top.sv
// Testbench top for the interrupt recording and error flag unit.
`default_nettype none
module ires_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, clk_en = 1, ovf_evt = 0, stk_evt = 0, lse_evt = 0, error_flags_wr = 0;
  logic flush_pending_irq_instr = 0, ack_allowed, return_from_handler_instr, irq_ack, global_irq_mask_flag;
  logic [7:0] irq_req = 0, irq_enable = 8'hFF, irq_ack_cause, irq_pending;
  logic [15:0] error_flags_wdata = 0, error_flags_rdata;
  int miscompares = 0, checked = 0, acks = 0;
  ires_top dut (.*);
  ires_seq_model seq (.core_clk, .rst, .irq_ack, .dly(4'h6), .ack_allowed, .return_from_handler_instr);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) acks += irq_ack;
  task chk(input logic [15:0] s, e);
    checked++;
    if (s !== e) begin miscompares++; $display("unexpected at %0t: %h vs %h", $time, s, e); end
  endtask
  task close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wack(input logic [7:0] c);
    int i = 0;
    do @(negedge core_clk); while (irq_ack !== 1'b1 && ++i < 60);
    if (i == 60) begin miscompares++; close_out; end
    chk(irq_ack_cause, c);
    chk(global_irq_mask_flag, 1'h1);
  endtask
  // Two requests at once, then repeats of one cause while masked.
  task t_mask;
    cyc(1); irq_req <= 8'h24;
    cyc(1); irq_req <= 0;
    wack(8'h04);
    cyc(1); irq_req <= 8'h04;
    cyc(1); irq_req <= 0;
    cyc(1); irq_req <= 8'h04;
    cyc(1); irq_req <= 0;
    wack(8'h04);
    wack(8'h20);
    cyc(12); #1;
    chk(global_irq_mask_flag, 1'h0);
    chk(acks, 3);
    $display("mask test done");
  endtask
  // Disabled cause still records, and flush discards it.
  task t_flush;
    irq_enable <= 0; irq_req <= 8'h02;
    cyc(1); irq_req <= 0;
    cyc(4); #1 chk(irq_pending, 8'h02);
    cyc(1); flush_pending_irq_instr <= 1;
    cyc(1); flush_pending_irq_instr <= 0; irq_enable <= 8'hFF;
    cyc(6); #1 chk(irq_pending, 8'h00);
    chk(acks, 3);
    $display("flush test done");
  endtask
  // Error events, a colliding write, and a write that clears the low flags while its writes to the high bits are ignored.
  task t_err;
    cyc(1); error_flags_wr <= 1; ovf_evt <= 1;
    cyc(1); error_flags_wr <= 0; ovf_evt <= 0; stk_evt <= 1;
    cyc(1); stk_evt <= 0; lse_evt <= 1;
    cyc(1); lse_evt <= 0;
    cyc(3); #1 chk(error_flags_rdata, 16'h000E);
    error_flags_wr <= 1; error_flags_wdata <= 16'hFFF1;
    cyc(1); error_flags_wr <= 0;
    cyc(3); #1 chk(error_flags_rdata, 16'h0000);
    $display("error test done");
  endtask
  initial begin
    cyc(2); rst <= 0;
    cyc(1); #1 chk(error_flags_rdata, 16'h0000);
    t_mask;
    t_flush;
    t_err;
    close_out;
  end
endmodule // ires_top_tb_top
bind ires_top ires_checker #(.N(N)) chk_i (.*);
`default_nettype wire
